// *** src/dalp_pkg.sv ***
// Summary of operation
// - Audio control bit 3 reads back the audio FIFO overrun flag.
// - Audio control bit 2 reads back the audio FIFO underrun flag.
// - Writing 1 to the FIFO error-reset bit clears recorded audio errors.
// - Edge-select 1 strobes audio data on rising edge, 0 on falling.
// - Pixel-clock test bit 7 selects the external test clock input.
// - Lock-mode 0: lock and video only while video-disabled indication is 0.
// - Lock-mode 1: lock whenever linked to a serializer, even without video.
// - Bit 5 makes back channel pass fast GPIO0 raw, unfiltered.
// - Bits 4-3: 00 auto, 01 dual, 10 single primary, 11 single secondary.
// - Port1 select: writes hit port1 and shared, reads return port1.
// - Port0 select (reset 1): writes hit port0 and shared, reads port0.
// - Both selects set: writes reach both ports, reads return port1.
// - Video-disabled indication means no active video; qualifies lock in lock-mode 0.
// - Auto-detect mode uses received dual-link indication for recovery.
package dalp_pkg;
  localparam logic [7:0] ADDR_AUDIO_CTL  = 8'h2b;
  localparam logic [7:0] ADDR_PCLK_TEST  = 8'h2e;
  localparam logic [7:0] ADDR_DUAL_RX    = 8'h34;
  localparam logic [7:0] RST_AUDIO_CTL   = 8'h00;
  localparam logic [7:0] RST_PCLK_TEST   = 8'h00;
  localparam logic [7:0] RST_DUAL_RX     = 8'h01;
  localparam int         BIT_OVERRUN     = 3;
  localparam int         BIT_UNDERRUN    = 2;
  localparam int         BIT_ERR_RESET   = 1;
  localparam int         BIT_RISE_EDGE   = 0;
  localparam int         BIT_EXT_PCLK    = 7;
  localparam int         BIT_LOCK_MODE   = 6;
  localparam int         BIT_RAW_BC      = 5;
  localparam int         BIT_MODE_HI     = 4;
  localparam int         BIT_MODE_LO     = 3;
  localparam int         BIT_SECOND_PORT_ACCESS_SELECT   = 1;
  localparam int         BIT_FIRST_PORT_ACCESS_SELECT   = 0;
  localparam logic [7:0] MASK_AUDIO_RW   = 8'hf3;
  localparam logic [7:0] MASK_PCLK_RW    = 8'hff;
  localparam logic [7:0] MASK_DUAL_RW    = 8'h7f;
  localparam logic [1:0] MODE_AUTO       = 2'h0;
  localparam logic [1:0] MODE_DUAL       = 2'h1;
  localparam logic [1:0] MODE_SINGLE_PRI = 2'h2;
  localparam logic [1:0] MODE_SINGLE_SEC = 2'h3;
endpackage

// *** src/dalp_regs.sv ***
`timescale 1ns/1ns
module dalp_regs
  import dalp_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_srst,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid,
  output logic            o_port0_shared_hit,
  input  wire logic       i_fifo_overrun,
  input  wire logic       i_fifo_underrun,
  input  wire logic       i_video_disabled,
  input  wire logic       i_serializer_linked,
  input  wire logic       i_remote_dual_link,
  input  wire logic       i_recovered_pclk_sel,
  input  wire logic       i_test_clock_input,
  input  wire logic       i_fast_gpio0_input,
  input  wire logic       i_fast_gpio0_filtered,
  output logic            o_audio_rise_edge,
  output logic            o_ext_pclk_sel,
  output logic            o_pclk,
  output logic            o_rx_lock,
  output logic            o_video_enable,
  output logic            o_backchannel_gpio0,
  output logic            o_dual_link,
  output logic            o_use_secondary,
  output logic [1:0]      o_port_write_en,
  output logic            o_read_port1
);
  import dalp_pkg::*;

  // Only the port-copy steering is visible here; other registers live
  // elsewhere and receive o_port_write_en alongside the shared write.
  logic [7:0] audio_ctl_r;
  logic [7:0] pclk_test_r;
  logic [7:0] dual_rx_r;
  logic       overrun_r;
  logic       underrun_r;
  logic       ovr_s;
  logic       udr_s;
  logic       vdis_s;
  logic       link_s;
  logic       rdual_s;
  logic       gpio_s;
  logic       wr_audio;
  logic       clr_err;

  // Every pin-side level except the test clock input and i_recovered_pclk_sel crosses on two flops. The two extra cycles of
  // latency are far below any host polling interval.
  dalp_sync2 u_sync_ovr  (.i_clk(i_clk), .i_srst(i_srst),
                          .i_d(i_fifo_overrun), .o_q(ovr_s));
  dalp_sync2 u_sync_udr  (.i_clk(i_clk), .i_srst(i_srst),
                          .i_d(i_fifo_underrun), .o_q(udr_s));
  dalp_sync2 u_sync_vdis (.i_clk(i_clk), .i_srst(i_srst),
                          .i_d(i_video_disabled), .o_q(vdis_s));
  dalp_sync2 u_sync_link (.i_clk(i_clk), .i_srst(i_srst),
                          .i_d(i_serializer_linked), .o_q(link_s));
  dalp_sync2 u_sync_dual (.i_clk(i_clk), .i_srst(i_srst),
                          .i_d(i_remote_dual_link), .o_q(rdual_s));
  dalp_sync2 u_sync_gpio (.i_clk(i_clk), .i_srst(i_srst),
                          .i_d(i_fast_gpio0_input), .o_q(gpio_s));

  assign wr_audio = i_wr && (i_addr == ADDR_AUDIO_CTL);
  assign clr_err  = wr_audio && i_wdata[BIT_ERR_RESET];

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      audio_ctl_r <= RST_AUDIO_CTL;
    end else if (wr_audio) begin
      audio_ctl_r <= i_wdata & MASK_AUDIO_RW;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pclk_test_r <= RST_PCLK_TEST;
    end else if (i_wr && (i_addr == ADDR_PCLK_TEST)) begin
      pclk_test_r <= i_wdata & MASK_PCLK_RW;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      dual_rx_r <= RST_DUAL_RX;
    end else if (i_wr && (i_addr == ADDR_DUAL_RX)) begin
      dual_rx_r <= i_wdata & MASK_DUAL_RW;
    end
  end

  // A new event in the clearing cycle wins, so no error is lost.
  // The error-reset bit is stored as written; each write of 1 clears
  // again, so a host need not write it back to 0 first.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      overrun_r  <= 1'b0;
      underrun_r <= 1'b0;
    end else begin
      overrun_r  <= ovr_s | (overrun_r & ~clr_err);
      underrun_r <= udr_s | (underrun_r & ~clr_err);
    end
  end

  // Read data is registered and holds until the next read, so a slow
  // host may pick it up late. Unmapped addresses read as zero.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        case (i_addr)
          ADDR_AUDIO_CTL: begin
            o_rdata <= {audio_ctl_r[7:4], overrun_r, underrun_r,
                        audio_ctl_r[1:0]};
          end
          ADDR_PCLK_TEST: o_rdata <= pclk_test_r;
          ADDR_DUAL_RX:   o_rdata <= dual_rx_r;
          default:        o_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Clock selection is a register-steered mux; a glitch-free clock
  // switch belongs to the clocking block that consumes o_ext_pclk_sel.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_audio_rise_edge <= 1'b0;
      o_ext_pclk_sel    <= 1'b0;
      o_pclk            <= 1'b0;
    end else begin
      o_audio_rise_edge <= audio_ctl_r[BIT_RISE_EDGE];
      o_ext_pclk_sel    <= pclk_test_r[BIT_EXT_PCLK];
      o_pclk            <= pclk_test_r[BIT_EXT_PCLK] ?
                           i_test_clock_input :
                           i_recovered_pclk_sel;
    end
  end

  // Lock needs a live link in both modes; lock mode only decides whether
  // missing video withholds it. Video output always waits for active
  // video, whatever the lock mode.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_rx_lock      <= 1'b0;
      o_video_enable <= 1'b0;
    end else begin
      if (dual_rx_r[BIT_LOCK_MODE]) begin
        o_rx_lock <= link_s;
      end else begin
        o_rx_lock <= link_s & ~vdis_s;
      end
      o_video_enable <= link_s & ~vdis_s;
    end
  end

  // The filtered level comes from same-domain filter logic and needs no
  // synchroniser; the raw path comes from a pin and does.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_backchannel_gpio0 <= 1'b0;
    end else if (dual_rx_r[BIT_RAW_BC]) begin
      o_backchannel_gpio0 <= gpio_s;
    end else begin
      o_backchannel_gpio0 <= i_fast_gpio0_filtered;
    end
  end

  // Forced modes ignore the remote dual-link indication; only auto-detect
  // follows it, after synchronisation.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dual_link     <= 1'b0;
      o_use_secondary <= 1'b0;
    end else begin
      case (dual_rx_r[BIT_MODE_HI:BIT_MODE_LO])
        MODE_AUTO: begin
          o_dual_link     <= rdual_s;
          o_use_secondary <= 1'b0;
        end
        MODE_DUAL: begin
          o_dual_link     <= 1'b1;
          o_use_secondary <= 1'b0;
        end
        MODE_SINGLE_PRI: begin
          o_dual_link     <= 1'b0;
          o_use_secondary <= 1'b0;
        end
        MODE_SINGLE_SEC: begin
          o_dual_link     <= 1'b0;
          o_use_secondary <= 1'b1;
        end
        default: begin
          o_dual_link     <= 1'b0;
          o_use_secondary <= 1'b0;
        end
      endcase
    end
  end

  // Port steering follows the select bits as they stand after each write.
  // Port0 copies are readable only with port1 select clear; port1 wins.
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_port_write_en    <= {1'b0, RST_DUAL_RX[BIT_FIRST_PORT_ACCESS_SELECT]};
      o_read_port1       <= 1'b0;
      o_port0_shared_hit <= 1'b0;
    end else begin
      o_port_write_en    <= {dual_rx_r[BIT_SECOND_PORT_ACCESS_SELECT],
                             dual_rx_r[BIT_FIRST_PORT_ACCESS_SELECT]};
      o_read_port1       <= dual_rx_r[BIT_SECOND_PORT_ACCESS_SELECT];
      o_port0_shared_hit <= dual_rx_r[BIT_FIRST_PORT_ACCESS_SELECT] &
                            ~dual_rx_r[BIT_SECOND_PORT_ACCESS_SELECT];
    end
  end
endmodule

// *** src/dalp_sync2.sv ***
`timescale 1ns/1ns
// Two-flop synchroniser for a single pin level.
module dalp_sync2 (
  input  wire logic i_clk,
  input  wire logic i_srst,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_r;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_r <= 1'b0;
      o_q    <= 1'b0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule

// *** verification/dalp_host.sv ***
`timescale 1ns/1ns
// Released address and data lines carry the inverse of their last value, so a stale address
// or byte is never mistaken for a live one.
module dalp_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output logic            o_wr = 1'b0,
  output logic            o_rd = 1'b0,
  output logic [7:0]      o_addr = 8'h00,
  output logic [7:0]      o_wdata = 8'h00
);
  task automatic access(input logic w, input logic [7:0] a, dt,
                        output logic [7:0] q, output logic ok);
    @(posedge i_clk);
    #1 {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, dt};
    @(posedge i_clk);
    #1 {o_wr, o_rd, o_addr, o_wdata} = {2'h0, ~a, ~dt};
    ok = w;
    q = i_rdata;
    for (int n = 0; n < 4 && !ok; n++) begin
      ok = i_rvalid;
      q = i_rdata;
      if (!ok) @(posedge i_clk) #1;
    end
  endtask
endmodule

// *** verification/dalp_regs_asserts.sv ***
`timescale 1ns/1ns
module dalp_regs_asserts (
  input wire logic       i_clk,
  input wire logic       i_srst,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic       o_rvalid,
  input wire logic       o_port0_shared_hit,
  input wire logic       i_fifo_overrun,
  input wire logic       i_fifo_underrun,
  input wire logic       o_audio_rise_edge,
  input wire logic       o_dual_link,
  input wire logic       o_use_secondary,
  input wire logic [1:0] o_port_write_en,
  input wire logic       o_read_port1
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_wr(logic [7:0] a);
    i_wr && i_addr == a;
  endsequence
  sequence s_rda;
    i_rd && i_addr == 8'h2b;
  endsequence
  AST_RVALID: assert property (i_rd |=> o_rvalid)
    else $error("no read valid");
  AST_OVR: assert property (i_fifo_overrun ##1 (!i_wr) [*3]
    ##0 s_rda |=> o_rdata[3]) else $error("overrun flag missing");
  AST_UDR: assert property (i_fifo_underrun ##1 (!i_wr) [*3]
    ##0 s_rda |=> o_rdata[2]) else $error("underrun flag missing");
  AST_CLR: assert property ((!i_fifo_overrun && !i_fifo_underrun) [*3]
    ##0 s_wr(8'h2b) ##0 i_wdata[1] ##2 s_rda |=> o_rdata[3:2] == 2'h0)
    else $error("flags not cleared");
  AST_EDGE: assert property (s_wr(8'h2b) |-> ##2
    o_audio_rise_edge == $past(i_wdata[0], 2)) else $error("edge select");
  AST_PORT: assert property (s_wr(8'h34) |-> ##2
    o_port_write_en == $past(i_wdata[1:0], 2)) else $error("port selects");
  AST_HIT: assert property (s_wr(8'h34) |-> ##2
    o_read_port1 == $past(i_wdata[1], 2) &&
    o_port0_shared_hit == ($past(i_wdata[1:0], 2) == 2'h1))
    else $error("read port");
  AST_MODE: assert property (s_wr(8'h34) ##0 i_wdata[4:3] != 2'h0 |-> ##2
    o_dual_link == ($past(i_wdata[4:3], 2) == 2'h1) &&
    o_use_secondary == ($past(i_wdata[4:3], 2) == 2'h3)) else $error("mode");
  AST_RST: assert property ($fell(i_srst) |->
    o_port_write_en == 2'h1 && !o_read_port1 && !o_rvalid)
    else $error("reset steering");
endmodule
bind dalp_regs dalp_regs_asserts u_chk (.*);

// *** verification/dalp_regs_bench.sv ***
`timescale 1ns/1ns
module dalp_regs_bench;
  import dalp_pkg::*;
  localparam logic [7:0] ADR [3] = '{ADDR_AUDIO_CTL, ADDR_PCLK_TEST,
                                     ADDR_DUAL_RX};
  localparam logic [7:0] MSK [3] = '{MASK_AUDIO_RW, MASK_PCLK_RW,
                                     MASK_DUAL_RW};
  logic       i_clk = 1'b0, i_srst = 1'b1, i_wr, i_rd, o_rvalid, ok;
  logic       i_fifo_overrun = 1'b0, i_fifo_underrun = 1'b0;
  logic       i_video_disabled = 1'b0, i_serializer_linked = 1'b0;
  logic       i_remote_dual_link = 1'b0, i_recovered_pclk_sel = 1'b0;
  logic       i_test_clock_input = 1'b0, i_fast_gpio0_input = 1'b0;
  logic       i_fast_gpio0_filtered = 1'b0, o_port0_shared_hit, o_pclk;
  logic       o_audio_rise_edge, o_ext_pclk_sel, o_rx_lock, o_video_enable;
  logic       o_backchannel_gpio0, o_dual_link, o_use_secondary, o_read_port1;
  logic [1:0] o_port_write_en;
  logic [7:0] i_addr, i_wdata, o_rdata, q, d, mdl [3];
  int         failures = 0, tests_run = 0, k;
  dalp_regs uut (.*);
  dalp_host host (.i_clk, .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_wr(i_wr),
                  .o_rd(i_rd), .o_addr(i_addr), .o_wdata(i_wdata));
  always #4 i_clk = ~i_clk;
  task automatic chk(input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic r(input logic [7:0] a, e);
    host.access(1'b0, a, 8'h00, q, ok);
    failures += !ok;
    if (!ok) stop_test();
    chk(q, e);
  endtask
  task automatic w(input int i, input logic [7:0] dt);
    host.access(1'b1, ADR[i], dt, q, ok);
    mdl[i] = (mdl[i] & ~MSK[i]) | (dt & MSK[i]);
    if (i == 0 && dt[1]) mdl[0][3:2] = 2'h0;
  endtask
  task automatic outs();
    chk(o_audio_rise_edge, mdl[0][0]);
    chk(o_ext_pclk_sel, mdl[1][7]);
    chk(o_pclk, mdl[1][7] ? i_test_clock_input :
        i_recovered_pclk_sel);
    chk(o_port_write_en, mdl[2][1:0]);
    chk(o_read_port1, mdl[2][1]);
    chk(o_port0_shared_hit, mdl[2][1:0] == 2'h1);
    chk(o_dual_link, mdl[2][4:3] == 2'h1 ||
        (mdl[2][4:3] == 2'h0 && i_remote_dual_link));
    chk(o_use_secondary, mdl[2][4:3] == 2'h3);
    chk(o_rx_lock, i_serializer_linked &&
        (mdl[2][6] || !i_video_disabled));
    chk(o_video_enable, i_serializer_linked && !i_video_disabled);
    chk(o_backchannel_gpio0, mdl[2][5] ? i_fast_gpio0_input :
        i_fast_gpio0_filtered);
  endtask
  initial begin
    void'($urandom(32'h8aa6));
    mdl = '{RST_AUDIO_CTL, RST_PCLK_TEST, RST_DUAL_RX};
    repeat (5) @(posedge i_clk);
    #1 i_srst = 1'b0;
    for (k = 0; k < 3; k++) r(ADR[k], mdl[k]);
    host.access(1'b1, 8'h40, 8'hff, q, ok);
    r(8'h40, 8'h00);
    for (k = 0; k < 24; k++) begin
      d = 8'($urandom);
      if (k % 3 == 2) d[4:3] = 2'(k / 3);
      w(k % 3, d);
      {i_video_disabled, i_serializer_linked, i_remote_dual_link,
       i_recovered_pclk_sel, i_test_clock_input, i_fast_gpio0_input,
       i_fast_gpio0_filtered} = 7'($urandom);
      // Inputs cross two synchroniser stages, so give them time to settle.
      repeat (5) @(posedge i_clk);
      #1 outs();
      r(ADR[k % 3], mdl[k % 3]);
    end
    // A reset in mid-run must restore the registers and the steering.
    i_srst = 1'b1;
    repeat (5) @(posedge i_clk);
    #1 i_srst = 1'b0;
    mdl = '{RST_AUDIO_CTL, RST_PCLK_TEST, RST_DUAL_RX};
    chk(o_port_write_en, 8'h01);
    chk(o_read_port1, 8'h00);
    repeat (3) @(posedge i_clk);
    #1 outs();
    for (k = 0; k < 3; k++) r(ADR[k], mdl[k]);
    for (k = 0; k < 2; k++) begin
      {i_fifo_overrun, i_fifo_underrun} = 2'h1 << k;
      @(posedge i_clk);
      #1 {i_fifo_overrun, i_fifo_underrun} = 2'h0;
      @(posedge i_clk);
      mdl[0][2 + k] = 1'b1;
      r(ADR[0], mdl[0]);
    end
    // An event that stands while the clear is written must survive it.
    i_fifo_overrun = 1'b1;
    repeat (2) @(posedge i_clk);
    w(0, 8'h02);
    i_fifo_overrun = 1'b0;
    mdl[0][3] = 1'b1;
    r(ADR[0], mdl[0]);
    w(0, 8'h02);
    r(ADR[0], mdl[0]);
    stop_test();
  end
endmodule
